// ==== wpcm_pkg.sv ====
package wpcm_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 9;
  localparam int SLOTS = 4;
  localparam int WORDS = 4;
  // ----------------------------------------
  // register indexes (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [6:0] IDX_ENABLE = 7'h2A;
  localparam logic [6:0] IDX_STATUS = 7'h2C;
  localparam logic [6:0] IDX_SLOT_BASE = 7'h30;
  localparam logic [6:0] IDX_SLOT_END = 7'h70;
  localparam logic [6:0] IDX_SLOT1_MASK1 = 7'h46;
  localparam logic [6:0] IDX_SLOT1_MASK2 = 7'h48;
  localparam logic [6:0] IDX_SLOT1_MASK3 = 7'h4A;
  localparam logic [6:0] IDX_SLOT2_CRC_LO = 7'h50;
  localparam logic [6:0] IDX_SLOT2_CRC_HI = 7'h52;
  localparam logic [6:0] IDX_SLOT2_MASK0 = 7'h54;
  localparam logic [6:0] IDX_SLOT2_MASK1 = 7'h56;
  localparam logic [6:0] IDX_SLOT2_MASK2 = 7'h58;
  localparam logic [6:0] IDX_SLOT2_MASK3 = 7'h5A;
  localparam logic [6:0] IDX_SLOT3_CRC_LO = 7'h60;
  localparam logic [6:0] IDX_SLOT3_CRC_HI = 7'h62;
  localparam logic [6:0] IDX_SLOT3_MASK0 = 7'h64;
  localparam logic [6:0] IDX_SLOT3_MASK1 = 7'h66;
  // ----------------------------------------
  // fields inside a slot (index low nibble)
  // ----------------------------------------
  localparam logic [3:0] FLD_CRC_LO = 4'h0;
  localparam logic [3:0] FLD_CRC_HI = 4'h2;
  localparam logic [3:0] FLD_MASK3 = 4'hA;
  localparam logic [1:0] MWORD_BIAS = 2'h2;
  localparam logic [1:0] SLOT_BIAS = 2'h1;
  // ----------------------------------------
  // reset values and crc
  // ----------------------------------------
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [6:0] MATCH_BYTES = 7'h40;
endpackage

// ==== wpcm_matcher.sv ====
`timescale 1ns/1ps
`default_nettype none
module wpcm_matcher (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [wpcm_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_last_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [3:0] wake_match_out,
  output logic wake_event_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] wpcm_crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ wpcm_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] crc_lo_r [wpcm_pkg::SLOTS];
  logic [15:0] crc_hi_r [wpcm_pkg::SLOTS];
  logic [15:0] mask_r [wpcm_pkg::SLOTS][wpcm_pkg::WORDS];
  logic [31:0] crc_r [wpcm_pkg::SLOTS];
  logic [31:0] crc_nxt [wpcm_pkg::SLOTS];
  logic [3:0] enable_r;
  logic [3:0] status_r;
  logic [3:0] match_r;
  logic event_r;
  logic [6:0] cnt_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire [6:0] idx = paddr_in[8:2];
  wire aligned = paddr_in[1:0] == 2'h0;
  wire slot_area = idx >= wpcm_pkg::IDX_SLOT_BASE && idx < wpcm_pkg::IDX_SLOT_END;
  wire [1:0] slot = idx[5:4] + wpcm_pkg::SLOT_BIAS;
  wire [3:0] fld = idx[3:0];
  wire [1:0] mword = fld[2:1] - wpcm_pkg::MWORD_BIAS;
  wire fld_ok = !fld[0] && fld <= wpcm_pkg::FLD_MASK3;
  wire hit_en = idx == wpcm_pkg::IDX_ENABLE;
  wire hit_st = idx == wpcm_pkg::IDX_STATUS;
  wire hit_slot = slot_area && fld_ok;
  wire mapped = aligned && (hit_en || hit_st || hit_slot);
  wire setup = psel_in && !penable_in && !pready_r;
  wire done = psel_in && penable_in && pready_r;
  wire wr_ok = done && pwrite_in && mapped;
  wire wr_lo = wr_ok && hit_slot && fld == wpcm_pkg::FLD_CRC_LO;
  wire wr_hi = wr_ok && hit_slot && fld == wpcm_pkg::FLD_CRC_HI;
  wire wr_mask = wr_ok && hit_slot && fld > wpcm_pkg::FLD_CRC_HI;
  wire [3:0] st_clr = (wr_ok && hit_st) ? pwdata_in[3:0] : wpcm_pkg::RST_FLAGS;
  wire [15:0] slot_rd = fld == wpcm_pkg::FLD_CRC_LO ? crc_lo_r[slot] :
                        fld == wpcm_pkg::FLD_CRC_HI ? crc_hi_r[slot] : mask_r[slot][mword];
  wire [31:0] rd_val = !mapped ? 32'h00000000 :
                       hit_en ? {28'h0000000, enable_r} :
                       hit_st ? {28'h0000000, status_r} : {16'h0000, slot_rd};

  // ----------------------------------------
  // apb response
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
      // writes answer zero so stale register data never looks like a read
      prdata_r <= (setup && !pwrite_in) ? rd_val : 32'h00000000;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      enable_r <= wpcm_pkg::RST_FLAGS;
    end else if (wr_ok && hit_en) begin
      enable_r <= pwdata_in[3:0];
    end
  end

  // ----------------------------------------
  // frame position
  // ----------------------------------------
  wire rx_fin = rx_valid_in && rx_last_in;
  wire in_win = cnt_r < wpcm_pkg::MATCH_BYTES;
  logic [3:0] sel;
  logic [3:0] hit;

  // count parks at 64, so long frames need no wider counter
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= 7'h00;
    end else if (rx_fin) begin
      cnt_r <= 7'h00;
    end else if (rx_valid_in && in_win) begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

  // ----------------------------------------
  // per slot storage and crc
  // ----------------------------------------
  for (genvar s = 0; s < wpcm_pkg::SLOTS; s++) begin : g_slot
    // upper count bits pick the word
    // byte n+1 from bit n%16 of word n/16
    assign sel[s] = in_win && mask_r[s][cnt_r[5:4]][cnt_r[3:0]];
    assign crc_nxt[s] = sel[s] ? wpcm_crc_byte(crc_r[s], rx_data_in) : crc_r[s];
    // full 32-bit compare, gated by enable
    assign hit[s] = enable_r[s] && (~crc_nxt[s] == {crc_hi_r[s], crc_lo_r[s]});

    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        crc_r[s] <= wpcm_pkg::CRC_INIT;
      end else if (rx_fin) begin
        crc_r[s] <= wpcm_pkg::CRC_INIT;
      end else if (rx_valid_in) begin
        crc_r[s] <= crc_nxt[s];
      end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        crc_lo_r[s] <= wpcm_pkg::RST_HALF;
        crc_hi_r[s] <= wpcm_pkg::RST_HALF;
      end else begin
        if (wr_lo && slot == 2'(s)) begin
          crc_lo_r[s] <= pwdata_in[15:0];
        end
        if (wr_hi && slot == 2'(s)) begin
          crc_hi_r[s] <= pwdata_in[15:0];
        end
      end
    end

    for (genvar w = 0; w < wpcm_pkg::WORDS; w++) begin : g_word
      // word index picks byte group of sixteen
      always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          mask_r[s][w] <= wpcm_pkg::RST_HALF;
        end else if (wr_mask && slot == 2'(s) && mword == 2'(w)) begin
          mask_r[s][w] <= pwdata_in[15:0];
        end
      end
    end
  end

  // ----------------------------------------
  // match outputs
  // ----------------------------------------
  // disabled slots never match
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      match_r <= wpcm_pkg::RST_FLAGS;
      event_r <= 1'b0;
      status_r <= wpcm_pkg::RST_FLAGS;
    end else begin
      match_r <= rx_fin ? hit : wpcm_pkg::RST_FLAGS;
      event_r <= rx_fin && (|hit);
      // set wins over a same-cycle clear
      status_r <= (status_r & ~st_clr) | (rx_fin ? hit : wpcm_pkg::RST_FLAGS);
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign wake_match_out = match_r;
  assign wake_event_out = event_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  first_byte_a: assert property (
    rx_valid_in && !rx_last_in && cnt_r == 7'h00 && !mask_r[0][0][0] |=> crc_r[0] == $past(crc_r[0]))
    else $error("unmasked first byte changed crc");

  byte17_a: assert property (
    rx_valid_in && !rx_last_in && cnt_r == 7'h10 && mask_r[2][1][0]
    |=> crc_r[2] == wpcm_crc_byte($past(crc_r[2]), $past(rx_data_in)))
    else $error("byte 17 not folded into crc");

  byte48_a: assert property (
    rx_valid_in && !rx_last_in && cnt_r == 7'h2F && mask_r[2][2][15]
    |=> crc_r[2] == wpcm_crc_byte($past(crc_r[2]), $past(rx_data_in)))
    else $error("byte 48 not folded into crc");

  past_window_a: assert property (
    rx_valid_in && !rx_last_in && cnt_r == wpcm_pkg::MATCH_BYTES |=> crc_r[2] == $past(crc_r[2]))
    else $error("byte beyond 64 changed crc");

  skip_byte_a: assert property (
    rx_valid_in && !rx_last_in && !sel[3] |=> $stable(crc_r[3]))
    else $error("unselected byte changed crc");

  crc_low_a: assert property (
    wr_lo && slot == 2'h2 |=> crc_lo_r[2] == $past(pwdata_in[15:0]) && $stable(crc_hi_r[2]))
    else $error("low crc half not written");

  crc_high_a: assert property (
    wr_hi && slot == 2'h2 |=> crc_hi_r[2] == $past(pwdata_in[15:0]))
    else $error("high crc half not written");

  slot_disable_a: assert property (
    rx_fin && !enable_r[2] |=> !wake_match_out[2])
    else $error("disabled slot reported a match");

  full_match_a: assert property (
    rx_fin && enable_r[2] && ~crc_nxt[2] == {crc_hi_r[2], crc_lo_r[2]}
    |=> wake_match_out[2] && wake_event_out ##1 !wake_match_out[2])
    else $error("expected crc match not reported");

  word3_first_a: assert property (
    rx_valid_in && !rx_last_in && cnt_r == 7'h30 && mask_r[2][3][0]
    |=> crc_r[2] == wpcm_crc_byte($past(crc_r[2]), $past(rx_data_in)))
    else $error("byte 49 not folded into crc");

  count_hold_a: assert property (
    rx_valid_in && !rx_last_in && !in_win |=> cnt_r == wpcm_pkg::MATCH_BYTES)
    else $error("byte count moved past the window");

  frame_restart_a: assert property (
    rx_fin |=> crc_r[3] == wpcm_pkg::CRC_INIT && cnt_r == 7'h00)
    else $error("frame end did not restart crc");

  mask_write_a: assert property (
    wr_mask && slot == 2'h2 && mword == 2'h1 |=> mask_r[2][1] == $past(pwdata_in[15:0]))
    else $error("mask word 1 not written");

  low_read_a: assert property (
    setup && !pwrite_in && aligned && hit_slot && fld == wpcm_pkg::FLD_CRC_LO && slot == 2'h3
    |=> prdata_out == {16'h0000, $past(crc_lo_r[3])})
    else $error("low crc half read back wrong");

  high_read_a: assert property (
    setup && !pwrite_in && aligned && hit_slot && fld == wpcm_pkg::FLD_CRC_HI && slot == 2'h3
    |=> prdata_out == {16'h0000, $past(crc_hi_r[3])})
    else $error("high crc half read back wrong");

  answer_pulse_a: assert property (
    pready_out |=> !pready_out)
    else $error("bus answer held longer than one cycle");

  write_quiet_a: assert property (
    pready_out && pwrite_in |-> prdata_out == 32'h00000000)
    else $error("write answered with read data");

  err_zero_a: assert property (
    pslverr_out |-> pready_out && prdata_out == 32'h00000000)
    else $error("refused access returned data");

  enable_write_a: assert property (
    wr_ok && hit_en |=> enable_r == $past(pwdata_in[3:0]))
    else $error("slot enable not written");

  event_or_a: assert property (
    wake_event_out == (|wake_match_out))
    else $error("wake event disagrees with slot matches");

  sticky_set_a: assert property (
    rx_fin && hit[2] |=> status_r[2])
    else $error("matched slot not latched in status");

  write_cov: cover property (wr_ok ##3 done && !pwrite_in);
  match_cov: cover property (rx_fin && |hit);
  err_cov: cover property (pslverr_out && pready_out);
  frame_end_cov: cover property (rx_fin ##1 wake_event_out);
  clear_cov: cover property (wr_ok && hit_st && |status_r);
endmodule
`default_nettype wire

// ==== wpcm_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// received frame byte source
// ----------------------------------------
module wpcm_rx_model (
  input wire logic mclk_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_last_out
);
  logic [7:0] frame_r [0:127];
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'hA5;
    rx_last_out = 1'b0;
  end
  // idle data is inverted so a stale byte is never mistaken for a live one
  task automatic send(input int len, input int gap);
    for (int i = 0; i < len; i++) begin
      rx_valid_out <= 1'b1;
      rx_data_out <= frame_r[i];
      rx_last_out <= (i == len - 1);
      @(posedge mclk_in);
      if (gap > 0) begin
        rx_valid_out <= 1'b0;
        rx_last_out <= 1'b0;
        rx_data_out <= ~frame_r[i];
        repeat (gap) @(posedge mclk_in);
      end
    end
    rx_valid_out <= 1'b0;
    rx_last_out <= 1'b0;
    rx_data_out <= ~frame_r[len - 1];
  endtask
endmodule
`default_nettype wire

// ==== wake_pattern_crc_matcher_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); end end
module wake_pattern_crc_matcher_tb;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [8:0] paddr = 9'h000;
  logic [31:0] pwdata = 32'h0, prdata_out, lfsr_r = 32'h02DD;
  logic pready_out, pslverr_out, rx_valid, rx_last, wake_event_out;
  logic [7:0] rx_data;
  logic [3:0] wake_match_out;
  logic [32:0] rq [$];
  logic [3:0] wq [$];
  logic [15:0] v [0:127];
  logic [32:0] r_exp;
  logic [4:0] w_exp;
  int n_fail = 0, compares = 0;
  always #50 mclk_in = ~mclk_in;
  wpcm_matcher i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .rx_valid_in(rx_valid),
    .rx_data_in(rx_data), .rx_last_in(rx_last), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .wake_match_out(wake_match_out), .wake_event_out(wake_event_out));
  wpcm_rx_model i_rx (.mclk_in(mclk_in), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .rx_last_out(rx_last));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r;
  endfunction
  // reflected crc32 over masked bytes, never past byte 64
  function automatic logic [31:0] crc_of(input logic [63:0] m, input int len);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < len && i < 64; i++) if (m[i]) begin
      c = c ^ {24'h0, i_rx.frame_r[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // reserved slot holes answer with an error and read zero
  task automatic apb(input logic wr, input logic [6:0] idx, input logic [15:0] d);
    logic err;
    int n;
    err = idx > 7'h40 && idx[3:0] > 4'hA;
    rq.push_back({err, 16'h0, (wr | err) ? 16'h0 : d});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= (rnd() & 32'hFFFF0000) | {16'h0000, d};
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge mclk_in); n++; end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) begin n_fail++; test_done(); end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic frame_test(input logic [1:0] s, input logic [63:0] m, input logic [31:0] flip,
      input logic [3:0] en, input int len, input int gap);
    logic [31:0] c;
    logic [6:0] b;
    logic ok;
    b = 7'h30 + {1'b0, s, 4'h0};
    for (int i = 0; i < 128; i++) i_rx.frame_r[i] = 8'(rnd());
    c = crc_of(m, len);
    ok = flip == 32'h0 && en[s];
    for (int j = 0; j < 4; j++) apb(1'b1, b + 7'(4 + 2 * j), m[16 * j +: 16]);
    apb(1'b1, b, c[15:0] ^ flip[15:0]);
    apb(1'b1, b + 7'h2, c[31:16] ^ flip[31:16]);
    apb(1'b1, 7'h2A, {12'h0, en});
    if (ok) wq.push_back(4'h1 << s);
    i_rx.send(len, gap);
    repeat (3) @(posedge mclk_in);
    `CHK(wq.size(), 0)
    apb(1'b0, 7'h2C, {12'h0, ok ? 4'h1 << s : 4'h0});
    apb(1'b1, 7'h2C, 16'h000F);
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge mclk_in) begin
    if (pready_out !== 1'b0) begin
      r_exp = rq.size() ? rq.pop_front() : 33'h0;
      `CHK({pslverr_out, prdata_out}, r_exp)
    end
    if (wake_event_out !== 1'b0 || wake_match_out !== 4'h0) begin
      w_exp = wq.size() ? {1'b1, wq.pop_front()} : 5'h0;
      `CHK({wake_event_out, wake_match_out}, w_exp)
    end
  end
  initial begin
    repeat (90000) @(posedge mclk_in);
    n_fail++;
    test_done();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    for (int k = 'h46; k <= 'h66; k += 2) apb(1'b0, 7'(k), 16'h0000);
    for (int k = 'h46; k <= 'h66; k += 2) begin
      v[k] = 16'(rnd());
      apb(1'b1, 7'(k), v[k]);
    end
    for (int k = 'h46; k <= 'h66; k += 2) apb(1'b0, 7'(k), v[k]);
    // first and last bit of every mask word
    for (int k = 0; k < 8; k++) frame_test(2'd2, 64'h1 << (16 * (k / 2) + 15 * (k % 2)), 0, 4'h4, 70, 0);
    // mixed mask, bytes past 64 present
    frame_test(2'd2, {rnd(), rnd()} | 64'h8001800180018001, 0, 4'h4, 70, 0);
    frame_test(2'd3, {rnd(), rnd()}, 0, 4'h8, 64, 2);
    frame_test(2'd2, {rnd(), rnd()}, 0, 4'h8, 40, 0);
    frame_test(2'd2, {rnd(), rnd()}, 32'h0001_0000, 4'h4, 30, 0);
    frame_test(2'd2, {rnd(), rnd()}, 32'h0000_8000, 4'h4, 30, 0);
    test_done();
  end
endmodule
`default_nettype wire
